// ==== mps_pkg.sv ====
// shared constants and types of the modem power and status controller
package mps_pkg;
   // clock and time figures
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned SOFT_ON_MS = 3000;
   localparam int unsigned HARD_RESET_MS = 100;
   localparam int unsigned SLOW_PERIOD_MS = 2000;
   localparam int unsigned FAST_PERIOD_MS = 1000;
   localparam int unsigned LAMP_BLIP_MS = 100;
   localparam logic [31:0] SOFT_ON_CYC = 32'(SOFT_ON_MS * CYC_PER_MS);
   localparam logic [31:0] HARD_RESET_CYC = 32'(HARD_RESET_MS * CYC_PER_MS);
   localparam logic [31:0] SLOW_HALF_CYC = 32'(SLOW_PERIOD_MS / 2 * CYC_PER_MS);
   localparam logic [31:0] FAST_HALF_CYC = 32'(FAST_PERIOD_MS / 2 * CYC_PER_MS);
   localparam logic [31:0] LAMP_BLIP_CYC = 32'(LAMP_BLIP_MS * CYC_PER_MS);
   // register byte offsets
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] CONFIG_OFS = 12'h004;
   localparam logic [11:0] STATE_OFS = 12'h008;
   localparam logic [11:0] IRQ_STATUS_OFS = 12'h00c;
   localparam logic [11:0] IRQ_MASK_OFS = 12'h010;
   // command strobe positions
   localparam int CMD_POWER_OFF = 0;
   localparam int CMD_FULL_FUNC = 1;
   localparam int CMD_SOFT_RESET = 2;
   localparam int CMD_ESCAPE = 3;
   localparam int CMD_ONLINE = 4;
   localparam int CMD_HANGUP = 5;
   localparam int CMD_DIAL = 6;
   localparam int CMD_W = 7;
   // config fields
   localparam int CFG_RING_LSB = 0;
   localparam int CFG_DTR_LSB = 4;
   localparam int CFG_DCD_BIT = 8;
   localparam int CFG_BAUD_LSB = 16;
   localparam int CFG_AUTO_BIT = 20;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0120;
   localparam logic [31:0] CONFIG_MASK = 32'h001f_0137;
   // ring and line settings
   localparam logic [2:0] RING_MAX = 3'h5;
   localparam logic [1:0] DTR_IGNORE = 2'h0;
   localparam logic [1:0] DTR_TO_CMD = 2'h1;
   localparam logic [1:0] DTR_HANGUP = 2'h2;
   // baud index: 0=300 1=600 2=1200 3=2400 4=4800 5=9600 6=19200 7=38400 8=57600 9=115200
   localparam logic [3:0] BAUD_LAST = 4'h9;
   localparam logic [3:0] AUTO_FIRST = 4'h3;
   localparam logic [3:0] AUTO_LAST = 4'h6;
   // state word fields
   localparam int ST_PWR_LSB = 0;
   localparam int ST_REG_BIT = 3;
   localparam int ST_CALL_BIT = 4;
   localparam int ST_DATA_BIT = 5;
   localparam int ST_PIN_BIT = 6;
   localparam int ST_CARD_BIT = 7;
   localparam int ST_DCD_BIT = 8;
   localparam int ST_AUTO_BIT = 9;
   localparam int ST_BAUD_LSB = 12;
   localparam int ST_ERR_LSB = 16;
   // interrupt events
   localparam int IRQ_CARD_IN = 0;
   localparam int IRQ_CARD_OUT = 1;
   localparam int IRQ_RING = 2;
   localparam int IRQ_ANSWER = 3;
   localparam int IRQ_W = 4;
   localparam logic [7:0] CME_CARD_GONE = 8'h0a;
   // power states, gray along off-wake-on-rf_off-restart
   typedef enum logic [2:0] {
      PWR_OFF = 3'b000,
      PWR_WAKE = 3'b001,
      PWR_ON = 3'b011,
      PWR_RF_OFF = 3'b010,
      PWR_RESTART = 3'b110
   } mps_pwr_t;
   // status lamp patterns
   typedef enum logic [1:0] {
      LAMP_DARK = 2'b00,
      LAMP_STEADY = 2'b01,
      LAMP_SLOW = 2'b11,
      LAMP_FAST = 2'b10
   } mps_lamp_t;
endpackage

// ==== mps_sync.sv ====
// two-stage pin synchroniser with edge pulses
`timescale 1ns/100ps
module mps_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pin and results
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta;
   logic prev;

   // meta feeds only level; edges compare level against its delayed copy
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= RESET_VAL;
         level <= RESET_VAL;
         prev <= RESET_VAL;
      end else begin
         meta <= pin;
         level <= meta;
         prev <= level;
      end
   end

   assign rise = level & ~prev;
   assign fall = ~level & prev;
endmodule

// ==== mps_lamp.sv ====
// status lamp pattern generator: dark, steady, slow or fast blink
`timescale 1ns/100ps
module mps_lamp #(
   parameter logic [31:0] SLOW_HALF = mps_pkg::SLOW_HALF_CYC,
   parameter logic [31:0] FAST_HALF = mps_pkg::FAST_HALF_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pattern select and lamp
   input wire mps_pkg::mps_lamp_t mode,
   output logic lamp
);
   mps_pkg::mps_lamp_t mode_q;
   logic [31:0] cnt;
   logic [31:0] half;

   assign half = (mode == mps_pkg::LAMP_FAST) ? FAST_HALF : SLOW_HALF;

   // equal high and low halves; a new pattern restarts with lamp high, except dark, which starts low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= mps_pkg::LAMP_DARK;
         cnt <= 32'h0000_0000;
         lamp <= 1'b0;
      end else begin
         mode_q <= mode;
         if (mode != mode_q) begin
            cnt <= 32'h0000_0000;
            lamp <= (mode != mps_pkg::LAMP_DARK);
         end else begin
            unique case (mode)
               mps_pkg::LAMP_DARK: begin
                  lamp <= 1'b0;
               end
               mps_pkg::LAMP_STEADY: begin
                  lamp <= 1'b1;
               end
               mps_pkg::LAMP_SLOW, mps_pkg::LAMP_FAST: begin
                  if (cnt >= half - 32'h0000_0001) begin
                     cnt <= 32'h0000_0000;
                     lamp <= ~lamp;
                  end else begin
                     cnt <= cnt + 32'h0000_0001;
                  end
               end
            endcase
         end
      end
   end
endmodule

// ==== mps_ctrl.sv ====
// modem power, status lamp, card, call and line control with apb registers
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/100ps
module mps_ctrl #(
   parameter logic [31:0] SOFT_ON_CYC = mps_pkg::SOFT_ON_CYC,
   parameter logic [31:0] HARD_RESET_CYC = mps_pkg::HARD_RESET_CYC,
   parameter logic [31:0] SLOW_HALF_CYC = mps_pkg::SLOW_HALF_CYC,
   parameter logic [31:0] FAST_HALF_CYC = mps_pkg::FAST_HALF_CYC,
   parameter logic [31:0] LAMP_BLIP_CYC = mps_pkg::LAMP_BLIP_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // control pins from the host
   input wire logic reg_enable_in,
   input wire logic hard_reset_n,
   input wire logic soft_on_in,
   input wire logic card_present_in,
   input wire logic dtr_in,
   input wire logic remote_carrier_in,
   input wire logic ring_in,
   input wire logic net_found_in,
   // status and line outputs
   output logic regulator_on,
   output logic radio_on,
   output logic status_lamp,
   output logic dcd_out,
   output logic off_hook,
   output logic data_mode,
   output logic pin_entry_ok,
   output logic error_report,
   output logic [7:0] error_code,
   output logic [3:0] baud_sel,
   output logic autobaud_on,
   output logic irq
);
   mps_pkg::mps_pwr_t pwr, next_pwr;
   mps_pkg::mps_lamp_t lamp_mode;
   logic en_lvl, hrst_lvl, soft_lvl, card_lvl, dcd_lvl;
   logic card_rise, card_fall, dtr_fall, ring_rise, net_rise;
   logic [31:0] tmr, rst_cnt, config_q, wmask, state_word, cfg_new;
   logic [mps_pkg::IRQ_W-1:0] irq_status, irq_mask, irq_event;
   logic [mps_pkg::CMD_W-1:0] cmd;
   logic [2:0] ring_cnt, ring_n;
   logic wr_en, rd_setup, addr_ok, hreset_hit, registered;
   logic online, powered, auto_answer, call_start, call_drop;
   logic [1:0] dtr_mode;

   // every pin passes two flops; enable, hard reset, card and dtr reset high, the others low
   mps_sync #(.RESET_VAL(1'b1)) u_en (.clk(pclk), .rst_n(presetn), .pin(reg_enable_in),
      .level(en_lvl), .rise(), .fall());
   mps_sync #(.RESET_VAL(1'b1)) u_hrst (.clk(pclk), .rst_n(presetn), .pin(hard_reset_n),
      .level(hrst_lvl), .rise(), .fall());
   mps_sync #(.RESET_VAL(1'b0)) u_soft (.clk(pclk), .rst_n(presetn), .pin(soft_on_in),
      .level(soft_lvl), .rise(), .fall());
   mps_sync #(.RESET_VAL(1'b1)) u_card (.clk(pclk), .rst_n(presetn), .pin(card_present_in),
      .level(card_lvl), .rise(card_rise), .fall(card_fall));
   mps_sync #(.RESET_VAL(1'b1)) u_dtr (.clk(pclk), .rst_n(presetn), .pin(dtr_in),
      .level(), .rise(), .fall(dtr_fall));
   mps_sync #(.RESET_VAL(1'b0)) u_dcd (.clk(pclk), .rst_n(presetn), .pin(remote_carrier_in),
      .level(dcd_lvl), .rise(), .fall());
   mps_sync #(.RESET_VAL(1'b0)) u_ring (.clk(pclk), .rst_n(presetn), .pin(ring_in),
      .level(), .rise(ring_rise), .fall());
   mps_sync #(.RESET_VAL(1'b0)) u_net (.clk(pclk), .rst_n(presetn), .pin(net_found_in),
      .level(), .rise(net_rise), .fall());

   // apb decode; write lands at the access edge with pready high
   assign wr_en = psel & penable & pready & pwrite;
   assign rd_setup = psel & ~penable;
   assign addr_ok = (paddr == mps_pkg::CTRL_OFS) || (paddr == mps_pkg::CONFIG_OFS) ||
      (paddr == mps_pkg::STATE_OFS) || (paddr == mps_pkg::IRQ_STATUS_OFS) ||
      (paddr == mps_pkg::IRQ_MASK_OFS);
   assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   assign cmd = (wr_en && paddr == mps_pkg::CTRL_OFS && pstrb[0]) ?
      pwdata[mps_pkg::CMD_W-1:0] : '0;
   assign online = (pwr == mps_pkg::PWR_ON);
   assign powered = online || (pwr == mps_pkg::PWR_RF_OFF);
   assign ring_n = config_q[mps_pkg::CFG_RING_LSB +: 3];
   assign dtr_mode = config_q[mps_pkg::CFG_DTR_LSB +: 2];
   assign hreset_hit = ~hrst_lvl && (rst_cnt == HARD_RESET_CYC - 32'h0000_0001);

   // answer on the n-th ring; zero or above five never answers
   assign auto_answer = ring_rise && !off_hook && ring_n != 3'h0 && ring_n <= mps_pkg::RING_MAX
      && (ring_cnt + 3'h1) == ring_n;
   assign call_start = cmd[mps_pkg::CMD_DIAL] | auto_answer;
   assign call_drop = cmd[mps_pkg::CMD_HANGUP] |
      (dtr_fall && dtr_mode == mps_pkg::DTR_HANGUP);
   assign cfg_new = (config_q & ~wmask) | (pwdata & wmask & mps_pkg::CONFIG_MASK);

   // read image of live state
   always_comb begin
      state_word = 32'h0000_0000;
      state_word[mps_pkg::ST_PWR_LSB +: 3] = pwr;
      state_word[mps_pkg::ST_REG_BIT] = registered;
      state_word[mps_pkg::ST_CALL_BIT] = off_hook;
      state_word[mps_pkg::ST_DATA_BIT] = data_mode;
      state_word[mps_pkg::ST_PIN_BIT] = pin_entry_ok;
      state_word[mps_pkg::ST_CARD_BIT] = ~card_lvl;
      state_word[mps_pkg::ST_DCD_BIT] = dcd_out;
      state_word[mps_pkg::ST_AUTO_BIT] = autobaud_on;
      state_word[mps_pkg::ST_BAUD_LSB +: 4] = baud_sel;
      state_word[mps_pkg::ST_ERR_LSB +: 8] = error_code;
   end

   // read data and ready prepared in setup, so access ends in one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= rd_setup;
         pslverr <= rd_setup & ~addr_ok;
         if (rd_setup) begin
            unique case (paddr)
               mps_pkg::CONFIG_OFS: prdata <= config_q;
               mps_pkg::STATE_OFS: prdata <= state_word;
               mps_pkg::IRQ_STATUS_OFS: prdata <= {28'h0000000, irq_status};
               mps_pkg::IRQ_MASK_OFS: prdata <= {28'h0000000, irq_mask};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // configuration; illegal baud index keeps the previous one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_q <= mps_pkg::CONFIG_RESET;
      end else if (wr_en && paddr == mps_pkg::CONFIG_OFS) begin
         if (cfg_new[mps_pkg::CFG_BAUD_LSB +: 4] <= mps_pkg::BAUD_LAST) begin
            config_q <= cfg_new;
         end else begin
            config_q <= {cfg_new[31:20], config_q[19:16], cfg_new[15:0]};
         end
      end
   end

   // baud select follows config; autobaud only inside 2400..19200
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_sel <= 4'h0;
         autobaud_on <= 1'b0;
      end else begin
         baud_sel <= config_q[mps_pkg::CFG_BAUD_LSB +: 4];
         autobaud_on <= config_q[mps_pkg::CFG_AUTO_BIT] &&
            config_q[mps_pkg::CFG_BAUD_LSB +: 4] >= mps_pkg::AUTO_FIRST &&
            config_q[mps_pkg::CFG_BAUD_LSB +: 4] <= mps_pkg::AUTO_LAST;
      end
   end

   // hard reset must stay low the full time; shorter dips are ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_cnt <= 32'h0000_0000;
      end else if (hrst_lvl) begin
         rst_cnt <= 32'h0000_0000;
      end else if (!hreset_hit) begin
         rst_cnt <= rst_cnt + 32'h0000_0001;
      end
   end

   // power sequence
   always_comb begin
      next_pwr = pwr;
      unique case (pwr)
         mps_pkg::PWR_OFF: if (soft_lvl) next_pwr = mps_pkg::PWR_WAKE;
         mps_pkg::PWR_WAKE: begin
            if (!soft_lvl) next_pwr = mps_pkg::PWR_OFF;
            else if (tmr == SOFT_ON_CYC - 32'h0000_0001) next_pwr = mps_pkg::PWR_ON;
         end
         mps_pkg::PWR_ON: begin
            if (cmd[mps_pkg::CMD_POWER_OFF]) begin
               next_pwr = soft_lvl ? mps_pkg::PWR_RF_OFF : mps_pkg::PWR_OFF;
            end else if (cmd[mps_pkg::CMD_SOFT_RESET]) begin
               next_pwr = mps_pkg::PWR_RESTART;
            end
         end
         mps_pkg::PWR_RF_OFF: begin
            if (cmd[mps_pkg::CMD_POWER_OFF] && !soft_lvl) next_pwr = mps_pkg::PWR_OFF;
            else if (cmd[mps_pkg::CMD_SOFT_RESET]) next_pwr = mps_pkg::PWR_RESTART;
            else if (cmd[mps_pkg::CMD_FULL_FUNC]) next_pwr = mps_pkg::PWR_ON;
         end
         mps_pkg::PWR_RESTART: begin
            if (tmr == LAMP_BLIP_CYC - 32'h0000_0001) next_pwr = mps_pkg::PWR_ON;
         end
         default: next_pwr = mps_pkg::PWR_OFF;
      endcase
      if (!en_lvl || hreset_hit) next_pwr = mps_pkg::PWR_OFF;
   end

   // state and its dwell timer, restarted on every change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr <= mps_pkg::PWR_OFF;
         tmr <= 32'h0000_0000;
      end else begin
         pwr <= next_pwr;
         tmr <= (next_pwr != pwr) ? 32'h0000_0000 : tmr + 32'h0000_0001;
      end
   end

   // supply and radio enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         regulator_on <= 1'b0;
         radio_on <= 1'b0;
      end else begin
         regulator_on <= en_lvl;
         radio_on <= (next_pwr == mps_pkg::PWR_ON);
      end
   end

   // registration needs radio and card; removal or restart drops it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         registered <= 1'b0;
      end else if (!online || card_rise) begin
         registered <= 1'b0;
      end else if (net_rise && !card_lvl) begin
         registered <= 1'b1;
      end
   end

   // card exchange: low means a card sits in the holder
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_entry_ok <= 1'b0;
         error_report <= 1'b0;
         error_code <= 8'h00;
      end else begin
         error_report <= powered & card_rise;
         if (powered && card_rise) error_code <= mps_pkg::CME_CARD_GONE;
         if (!powered || card_rise) pin_entry_ok <= 1'b0;
         else if (card_fall) pin_entry_ok <= 1'b1;
      end
   end

   // ring counter, cleared while a call stands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ring_cnt <= 3'h0;
      end else if (!online || off_hook) begin
         ring_cnt <= 3'h0;
      end else if (ring_rise && ring_cnt != 3'h7) begin
         ring_cnt <= ring_cnt + 3'h1;
      end
   end

   // call and data mode; a new call enters data mode at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off_hook <= 1'b0;
         data_mode <= 1'b0;
      end else if (!online) begin
         off_hook <= 1'b0;
         data_mode <= 1'b0;
      end else if (call_start) begin
         off_hook <= 1'b1;
         data_mode <= 1'b1;
      end else if (call_drop) begin
         off_hook <= 1'b0;
         data_mode <= 1'b0;
      end else if (cmd[mps_pkg::CMD_ESCAPE] ||
         (dtr_fall && dtr_mode == mps_pkg::DTR_TO_CMD)) begin
         data_mode <= 1'b0;
      end else if (cmd[mps_pkg::CMD_ONLINE] && off_hook) begin
         data_mode <= 1'b1;
      end
   end

   // carrier detect forced on, or following the far carrier
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dcd_out <= 1'b1;
      end else begin
         dcd_out <= config_q[mps_pkg::CFG_DCD_BIT] ? dcd_lvl : 1'b1;
      end
   end

   // lamp pattern from power, registration and call
   always_comb begin
      if (!powered) lamp_mode = mps_pkg::LAMP_DARK;
      else if (!online || !registered) lamp_mode = mps_pkg::LAMP_STEADY;
      else if (off_hook) lamp_mode = mps_pkg::LAMP_FAST;
      else lamp_mode = mps_pkg::LAMP_SLOW;
   end

   mps_lamp #(.SLOW_HALF(SLOW_HALF_CYC), .FAST_HALF(FAST_HALF_CYC)) u_lamp (
      .clk(pclk), .rst_n(presetn), .mode(lamp_mode), .lamp(status_lamp));

   // sticky events, set beats a simultaneous write-one clear
   assign irq_event = {auto_answer, ring_rise & online, card_rise & powered, card_fall & powered};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= '0;
         irq_mask <= '0;
         irq <= 1'b0;
      end else begin
         if (wr_en && paddr == mps_pkg::IRQ_STATUS_OFS && pstrb[0]) begin
            irq_status <= (irq_status & ~pwdata[mps_pkg::IRQ_W-1:0]) | irq_event;
         end else begin
            irq_status <= irq_status | irq_event;
         end
         if (wr_en && paddr == mps_pkg::IRQ_MASK_OFS && pstrb[0]) begin
            irq_mask <= pwdata[mps_pkg::IRQ_W-1:0];
         end
         irq <= |(irq_status & irq_mask);
      end
   end
endmodule

// ==== mps_asserts.sv ====
// port assertions of the modem power and status controller
`timescale 1ns/100ps
module mps_asserts (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // watched ports
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic reg_enable_in,
   input wire logic regulator_on,
   input wire logic radio_on,
   input wire logic status_lamp,
   input wire logic off_hook,
   input wire logic data_mode,
   input wire logic error_report,
   input wire logic [7:0] error_code,
   input wire logic [3:0] baud_sel,
   input wire logic autobaud_on
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // pin low long enough to cross the two sync flops and the output flop
   sequence s_en_low;
      !reg_enable_in [*4];
   endsequence
   // extra margin for the power state and the lamp stage behind it
   sequence s_en_dark;
      !reg_enable_in [*8];
   endsequence
   sequence s_setup;
      psel && !penable;
   endsequence
   reg_off_a: assert property (s_en_low |-> !regulator_on)
      else $error("regulator on with enable low");
   engine_dark_a: assert property (s_en_dark |-> !radio_on && !status_lamp)
      else $error("engine or lamp alive with enable low");
   ready_next_a: assert property (s_setup |=> pready)
      else $error("no ready after setup");
   ready_slot_a: assert property (pready |-> psel && penable && $past(psel) && !$past(penable))
      else $error("ready outside first access cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("slave error without ready");
   card_err_a: assert property (error_report |=> !error_report && error_code == 8'h0a)
      else $error("card error report wrong");
   baud_range_a: assert property (baud_sel <= 4'h9)
      else $error("baud index out of range");
   auto_range_a: assert property (autobaud_on |-> baud_sel inside {[4'h3:4'h6]})
      else $error("autobaud outside its rates");
   call_data_a: assert property ($rose(off_hook) |-> ##[0:1] data_mode)
      else $error("call start without data mode");
endmodule
bind mps_ctrl mps_asserts i_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .reg_enable_in, .regulator_on, .radio_on, .status_lamp, .off_hook, .data_mode,
   .error_report, .error_code, .baud_sel, .autobaud_on);

// ==== mps_host.sv ====
// host model: soft-on pulse, open-collector reset and card lines
`timescale 1ns/100ps
module mps_host #(
   parameter int ON_CYC = 50,
   parameter int RST_CYC = 30
) (
   // clock
   input wire logic pclk,
   // bench requests
   input wire logic on_req,
   input wire logic keep_on,
   input wire logic rst_req,
   input wire logic card_pull,
   // pins
   output logic soft_on_in,
   output logic hard_reset_n,
   output logic card_present_in
);
   int on_cnt = 0;
   int rst_cnt = 0;
   // pulse lengths outlast the device's wake and reset filters
   always @(posedge pclk) begin
      on_cnt <= on_req ? ON_CYC : (on_cnt > 0 ? on_cnt - 1 : 0);
      rst_cnt <= rst_req ? RST_CYC : (rst_cnt > 0 ? rst_cnt - 1 : 0);
   end
   // released reset and card lines float high through their pull-ups; soft-on rests low when released
   assign soft_on_in = keep_on || on_cnt > 0;
   assign hard_reset_n = !(rst_cnt > 0);
   assign card_present_in = !card_pull;
endmodule

// ==== test_modem_power_status_control.sv ====
// self-checking bench of the modem power and status controller
`timescale 1ns/100ps
module test_modem_power_status_control;
   localparam logic [31:0] SH = 32'h8;
   localparam logic [31:0] FH = 32'h4;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r, m_cfg = 32'h0000_0120;
   logic [3:0] pstrb = 4'hf, baud_sel;
   logic [7:0] error_code;
   logic reg_enable_in = 1, dtr_in = 1, remote_carrier_in = 0, ring_in = 0, net_found_in = 0;
   logic on_req = 0, keep_on = 0, rst_req = 0, card_pull = 0;
   logic soft_on_in, hard_reset_n, card_present_in, regulator_on, radio_on, status_lamp;
   logic dcd_out, off_hook, data_mode, pin_entry_ok, error_report, autobaud_on, irq;
   int miscompares = 0, checked = 0, b, k, n;
   always #2 pclk = ~pclk;
   mps_host i_host (.pclk, .on_req, .keep_on, .rst_req, .card_pull, .soft_on_in,
      .hard_reset_n, .card_present_in);
   // short counts keep the run brief
   mps_ctrl #(.SOFT_ON_CYC(32'h28), .HARD_RESET_CYC(32'h14), .SLOW_HALF_CYC(SH),
      .FAST_HALF_CYC(FH), .LAMP_BLIP_CYC(32'ha)) i_dut (.pclk, .presetn, .paddr, .psel,
      .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .reg_enable_in,
      .hard_reset_n, .soft_on_in, .card_present_in, .dtr_in, .remote_carrier_in, .ring_in,
      .net_found_in, .regulator_on, .radio_on, .status_lamp, .dcd_out, .off_hook,
      .data_mode, .pin_entry_ok, .error_report, .error_code, .baud_sel, .autobaud_on, .irq);
   task automatic stop_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checked++;
      if (g !== x) begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic tmo;
      miscompares++;
      $display("MISMATCH at %0t: wait ran out", $time);
      stop_test();
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge pclk);
   endtask
   task automatic wfor(ref logic s, input logic v);
      for (int i = 0; i < 300 && s !== v; i++)
         @(posedge pclk);
      if (s !== v)
         tmo();
   endtask
   // one apb transfer, held until ready is sampled
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      for (int i = 0; i < 20 && pready !== 1; i++)
         @(posedge pclk);
      if (pready !== 1)
         tmo();
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(0, a, 0);
      chk(r, x);
   endtask
   task automatic cmd(input int bitn);
      apb(1, mps_pkg::CTRL_OFS, 32'h1 << bitn);
   endtask
   // model: an out-of-range baud index keeps the old one
   task automatic wcfg(input logic [31:0] d);
      apb(1, mps_pkg::CONFIG_OFS, d);
      m_cfg = d[19:16] > 4'h9 ? (d & 32'h0010_0137) | (m_cfg & 32'h000f_0000) : d & 32'h001f_0137;
      rd(mps_pkg::CONFIG_OFS, m_cfg);
   endtask
   // measures the high half, then the full period
   task automatic per(input logic [31:0] x);
      int c = 0;
      wfor(status_lamp, 0);
      wfor(status_lamp, 1);
      for (; status_lamp === 1 && c < 99; c++)
         @(posedge pclk);
      chk(32'(c), x / 2);
      for (; status_lamp === 0 && c < 99; c++)
         @(posedge pclk);
      chk(32'(c), x);
   endtask
   task automatic rings(input int c);
      repeat (c) begin
         ring_in <= 1;
         tick(6);
         ring_in <= 0;
         tick(6);
      end
   endtask
   initial begin
      r = $urandom(39756);
      tick(20);
      presetn <= 1;
      tick(1);
      rd(mps_pkg::CONFIG_OFS, m_cfg);
      rd(12'h014, 32'h0);
      chk(32'(e), 32'h1);
      chk(32'(dcd_out), 32'h0);
      remote_carrier_in <= 1;
      tick(4);
      chk(32'(dcd_out), 32'h1);
      remote_carrier_in <= 0;
      wcfg(32'h0000_0020);
      tick(3);
      chk(32'(dcd_out), 32'h1);
      b = $urandom % 10;
      wcfg(32'h0010_0020 | 32'(b) << 16);
      wcfg(32'h001a_0020);
      apb(0, mps_pkg::STATE_OFS, 0);
      chk(r & 32'hf200, 32'(b) << 12 | (b >= 3 && b <= 6 ? 32'h200 : 32'h0));
      apb(1, mps_pkg::IRQ_MASK_OFS, 32'hf);
      on_req <= 1;
      tick(1);
      on_req <= 0;
      wfor(radio_on, 1);
      tick(4);
      chk(32'(status_lamp), 32'h1);
      card_pull <= 1;
      wfor(pin_entry_ok, 1);
      tick(2);
      chk(32'(irq), 32'h1);
      rd(mps_pkg::IRQ_STATUS_OFS, 32'h1);
      apb(1, mps_pkg::IRQ_STATUS_OFS, 32'h1);
      tick(2);
      chk(32'(irq), 32'h0);
      net_found_in <= 1;
      per(2 * SH);
      cmd(mps_pkg::CMD_DIAL);
      per(2 * FH);
      cmd(mps_pkg::CMD_ESCAPE);
      chk(32'(data_mode), 32'h0);
      cmd(mps_pkg::CMD_ONLINE);
      chk(32'(data_mode), 32'h1);
      // each terminal-ready mode against a line drop mid-call
      for (k = 0; k < 3; k++) begin
         cmd(mps_pkg::CMD_HANGUP);
         cmd(mps_pkg::CMD_DIAL);
         wcfg((m_cfg & ~32'h30) | 32'(k) << 4);
         dtr_in <= 0;
         tick(6);
         chk(32'(off_hook), 32'(k != 2));
         if (k < 2) chk(32'(data_mode), 32'(k == 0));
         dtr_in <= 1;
         tick(6);
      end
      n = 1 + $urandom % 5;
      wcfg((m_cfg & ~32'h7) | 32'(n));
      rings(n - 1);
      chk(32'(off_hook), 32'h0);
      rings(1);
      chk(32'(off_hook), 32'h1);
      cmd(mps_pkg::CMD_HANGUP);
      wcfg(m_cfg & ~32'h7);
      rings(6);
      chk(32'(off_hook), 32'h0);
      apb(1, mps_pkg::IRQ_STATUS_OFS, 32'hf);
      card_pull <= 0;
      wfor(error_report, 1);
      tick(1);
      chk(32'(error_code), 32'h0a);
      rd(mps_pkg::IRQ_STATUS_OFS, 32'h2);
      cmd(mps_pkg::CMD_SOFT_RESET);
      wfor(status_lamp, 0);
      wfor(status_lamp, 1);
      apb(0, mps_pkg::STATE_OFS, 0);
      chk(r & 32'h4f, 32'h03);
      rst_req <= 1;
      tick(1);
      rst_req <= 0;
      wfor(radio_on, 0);
      keep_on <= 1;
      wfor(radio_on, 1);
      cmd(mps_pkg::CMD_POWER_OFF);
      tick(3);
      chk(32'({radio_on, status_lamp}), 32'h1);
      cmd(mps_pkg::CMD_FULL_FUNC);
      tick(3);
      chk(32'(radio_on), 32'h1);
      keep_on <= 0;
      tick(5);
      cmd(mps_pkg::CMD_POWER_OFF);
      tick(6);
      chk(32'({radio_on, status_lamp}), 32'h0);
      on_req <= 1;
      tick(1);
      on_req <= 0;
      wfor(radio_on, 1);
      reg_enable_in <= 0;
      tick(8);
      chk(32'({regulator_on, radio_on}), 32'h0);
      stop_test();
   end
endmodule
